// [logic/tmu_pkg.sv]
package tmu_pkg;

    // ========================================
    // Register byte offsets
    localparam logic [7:0] OFS_RUN    = 8'h00;
    localparam logic [7:0] OFS_MODE   = 8'h04;
    localparam logic [7:0] OFS_CLK    = 8'h08;
    localparam logic [7:0] OFS_TFF    = 8'h0C;
    localparam logic [7:0] OFS_SCMP_A = 8'h10;
    localparam logic [7:0] OFS_MCMP_A = 8'h14;
    localparam logic [7:0] OFS_SCMP_B = 8'h18;
    localparam logic [7:0] OFS_MCMP_B = 8'h1C;
    localparam logic [7:0] OFS_CNT    = 8'h20;
    localparam logic [7:0] OFS_POL    = 8'h24;

    // ========================================
    // Values after reset and field positions
    localparam logic [7:0] RST_RUN   = 8'h00;
    localparam logic [7:0] RST_MODE  = 8'h00;
    localparam logic [7:0] RST_CLK   = 8'h00;
    localparam logic [7:0] RST_TFF   = 8'h00;
    localparam logic [7:0] RST_CMP   = 8'h00;
    localparam logic [1:0] RST_POL   = 2'h0;
    localparam logic [1:0] RST_C16   = 2'h3;
    localparam int         PRE_RUN_BIT = 5;
    localparam int         INV_EN_BIT  = 1;
    localparam logic [7:0] TFF_CMD_RD  = 8'hCC;

    // ========================================
    // Prescaler timing
    localparam int CLK_MHZ   = 40;
    localparam int TAP1_NS   = 500;
    localparam int TAP16_NS  = 8000;
    localparam int TAP256_NS = 128000;
    localparam int TAP1_CYC  = (TAP1_NS * CLK_MHZ) / 1000;
    localparam int TAP16_DIV = TAP16_NS / TAP1_NS;
    localparam int TAP256_DIV = TAP256_NS / TAP1_NS;

    // ========================================
    // Encodings
    typedef enum logic [1:0] {
        MODE_8BIT  = 2'h0,
        MODE_16BIT = 2'h1,
        MODE_PULSE = 2'h2,
        MODE_PWM   = 2'h3
    } tmu_mode_t;

    typedef enum logic [1:0] {
        FF_CLR  = 2'h0,
        FF_SET  = 2'h1,
        FF_INV  = 2'h2,
        FF_KEEP = 2'h3
    } tmu_ffcmd_t;

    localparam logic [1:0] SEL_SUB  = 2'h0;
    localparam logic [1:0] SEL_T1   = 2'h1;
    localparam logic [1:0] SEL_T16  = 2'h2;
    localparam logic [1:0] SEL_PRESCALE_TAP_256 = 2'h3;
    localparam logic [1:0] PWM_N6   = 2'h1;
    localparam logic [1:0] PWM_N7   = 2'h2;
    localparam logic [7:0] PER_N6   = 8'h3F;
    localparam logic [7:0] PER_N7   = 8'h7F;
    localparam logic [7:0] PER_N8   = 8'hFF;

endpackage

// [logic/tmu_unit_if.sv]
`timescale 1ns/10ps
interface tmu_unit_if;
    logic                 sub_run;
    logic                 main_run;
    tmu_pkg::tmu_mode_t   mode;
    logic [1:0]           pwm_n;
    logic [1:0]           sub_sel;
    logic [1:0]           main_sel;
    logic                 inv_en;
    logic                 ff_cmd_valid;
    tmu_pkg::tmu_ffcmd_t  ff_cmd;
    logic [7:0]           sub_cmp;
    logic [7:0]           main_cmp;
    logic                 cmp16_en;
    logic [2:0]           tap;
    logic [7:0]           sub_cnt;
    logic [7:0]           main_cnt;
    logic                 tff;
    logic                 trig;

    modport top (
        output sub_run, main_run, mode, pwm_n, sub_sel, main_sel,
        output inv_en, ff_cmd_valid, ff_cmd, sub_cmp, main_cmp,
        output cmp16_en, tap,
        input  sub_cnt, main_cnt, tff, trig
    );
    modport unit (
        input  sub_run, main_run, mode, pwm_n, sub_sel, main_sel,
        input  inv_en, ff_cmd_valid, ff_cmd, sub_cmp, main_cmp,
        input  cmp16_en, tap,
        output sub_cnt, main_cnt, tff, trig
    );
endinterface

// [logic/tmu_unit.sv]
`timescale 1ns/10ps
module tmu_unit (
    // Clock and reset
    input  wire logic   clk_i,
    input  wire logic   rst_b_i,
    // Control and status
    tmu_unit_if.unit    u
);

    // ========================================
    // Clock source selection
    function automatic logic sel_tick(input logic [1:0] sel,
                                      input logic [2:0] tap);
        case (sel)
            tmu_pkg::SEL_T1:   sel_tick = tap[0];
            tmu_pkg::SEL_T16:  sel_tick = tap[1];
            tmu_pkg::SEL_PRESCALE_TAP_256: sel_tick = tap[2];
            default:           sel_tick = 1'b0;
        endcase
    endfunction

    logic [7:0]  sub_q;
    logic [7:0]  main_q;
    logic        tff_q;
    logic        trig_q;
    logic [7:0]  s_nxt;
    logic [7:0]  m_nxt;
    logic [7:0]  period;
    logic [15:0] w_nxt;
    logic        m16;
    logic        s_tick;
    logic        s_match;
    logic        s_ovf;
    logic        m_tick;
    logic        m_match;
    logic        w_match;
    logic        per_hit;
    logic        hit;
    logic        clr_m;
    logic        tog;

    // ========================================
    // Tick, match and event decoding
    always_comb begin
        m16    = (u.mode == tmu_pkg::MODE_16BIT);
        s_tick = u.sub_run & sel_tick(u.sub_sel, u.tap)
                 & ~(m16 & (u.sub_sel == tmu_pkg::SEL_PRESCALE_TAP_256));
        s_nxt  = sub_q + 8'h01;
        s_match = s_tick & (s_nxt == u.sub_cmp);
        s_ovf   = s_tick & (sub_q == 8'hFF);
        m_nxt   = main_q + 8'h01;
        w_nxt   = {main_q, sub_q} + 16'h0001;
        w_match = s_tick & u.cmp16_en
                  & (w_nxt == {u.main_cmp, u.sub_cmp});
        if (m16) begin
            m_tick = u.main_run & s_ovf;
        end else if (u.main_sel == tmu_pkg::SEL_SUB) begin
            m_tick = u.main_run & s_match;
        end else begin
            m_tick = u.main_run & sel_tick(u.main_sel, u.tap);
        end
        if (u.mode == tmu_pkg::MODE_PULSE) begin
            m_tick = m_tick & u.sub_run;
        end
        case (u.pwm_n)
            tmu_pkg::PWM_N6: period = tmu_pkg::PER_N6;
            tmu_pkg::PWM_N7: period = tmu_pkg::PER_N7;
            default:         period = tmu_pkg::PER_N8;
        endcase
        m_match = m_tick & (m_nxt == u.main_cmp);
        per_hit = m_tick & (m_nxt == period);
        case (u.mode)
            tmu_pkg::MODE_16BIT: begin
                hit   = w_match;
                clr_m = w_match;
                tog   = w_match;
            end
            tmu_pkg::MODE_PULSE: begin
                hit   = m_match;
                clr_m = m_match;
                tog   = m_match | (m_tick & (m_nxt == u.sub_cmp));
            end
            tmu_pkg::MODE_PWM: begin
                hit   = per_hit;
                clr_m = per_hit;
                tog   = m_match | per_hit;
            end
            default: begin
                hit   = m_match;
                clr_m = m_match;
                tog   = m_match;
            end
        endcase
    end

    // ========================================
    // Sub counter
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sub_q <= 8'h00;
        end else if (!u.sub_run || u.mode == tmu_pkg::MODE_PULSE) begin
            sub_q <= 8'h00;
        end else if (m16) begin
            if (w_match) begin
                sub_q <= 8'h00;
            end else if (s_tick) begin
                sub_q <= s_nxt;
            end
        end else if (s_match) begin
            sub_q <= 8'h00;
        end else if (s_tick) begin
            sub_q <= s_nxt;
        end
    end

    // ========================================
    // Main counter
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            main_q <= 8'h00;
        end else if (!u.main_run) begin
            main_q <= 8'h00;
        end else if (clr_m) begin
            main_q <= 8'h00;
        end else if (m_tick) begin
            main_q <= m_nxt;
        end
    end

    // ========================================
    // Output flip-flop and trigger
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tff_q <= 1'b0;
        end else if (u.ff_cmd_valid) begin
            case (u.ff_cmd)
                tmu_pkg::FF_CLR: tff_q <= 1'b0;
                tmu_pkg::FF_SET: tff_q <= 1'b1;
                tmu_pkg::FF_INV: tff_q <= ~tff_q;
                default:         tff_q <= tff_q;
            endcase
        end else if (tog && u.inv_en) begin
            tff_q <= ~tff_q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trig_q <= 1'b0;
        end else begin
            trig_q <= hit;
        end
    end

    assign u.sub_cnt  = sub_q;
    assign u.main_cnt = main_q;
    assign u.tff      = tff_q;
    assign u.trig     = trig_q;

endmodule

// [logic/tmu_top.sv]
`timescale 1ns/10ps
module tmu_top (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Timer outputs
    output logic             pulse_out_a_o,
    output logic             pulse_out_b_o,
    output logic [1:0]       irq_trig_o
);

    localparam logic [4:0] PRE_LAST = 5'(tmu_pkg::TAP1_CYC - 1);
    localparam logic [7:0] T16_LAST = 8'(tmu_pkg::TAP16_DIV - 1);
    localparam logic [7:0] PRESCALE_TAP_256_LAST = 8'(tmu_pkg::TAP256_DIV - 1);
    localparam logic [4:0] GAP_IDLE  = 5'h1F;

    // ========================================
    // Address decoding
    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            tmu_pkg::OFS_RUN, tmu_pkg::OFS_MODE, tmu_pkg::OFS_CLK,
            tmu_pkg::OFS_TFF, tmu_pkg::OFS_SCMP_A, tmu_pkg::OFS_MCMP_A,
            tmu_pkg::OFS_SCMP_B, tmu_pkg::OFS_MCMP_B, tmu_pkg::OFS_CNT,
            tmu_pkg::OFS_POL: is_mapped = 1'b1;
            default:          is_mapped = 1'b0;
        endcase
    endfunction

    logic [7:0]  run_q;
    logic [7:0]  mode_q;
    logic [7:0]  clk_q;
    logic [7:0]  tff_q;
    logic [7:0]  scmp_q [2];
    logic [7:0]  mcmp_q [2];
    logic [1:0]  c16_q;
    logic [1:0]  pol_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rd_d;
    logic        access;
    logic        wr_en;
    logic [4:0]  pre_q;
    logic [7:0]  div_q;
    logic [2:0]  tap_q;
    logic        wrap;
    logic        pulse_a_q;
    logic        pulse_b_q;

    tmu_unit_if uif[2] ();

    assign access = psel_i & penable_i;
    assign wr_en  = access & pwrite_i & pready_q;

    // ========================================
    // APB handshake, one wait state
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= access & ~pready_q;
            pslverr_q <= access & ~pready_q & ~is_mapped(paddr_i);
            if (access && !pready_q && !pwrite_i) begin
                prdata_q <= rd_d;
            end
        end
    end

    always_comb begin
        case (paddr_i)
            tmu_pkg::OFS_RUN:  rd_d = {24'h00_0000, run_q};
            tmu_pkg::OFS_MODE: rd_d = {24'h00_0000, mode_q};
            tmu_pkg::OFS_CLK:  rd_d = {24'h00_0000, clk_q};
            tmu_pkg::OFS_TFF:  rd_d = {24'h00_0000,
                                       tff_q | tmu_pkg::TFF_CMD_RD};
            tmu_pkg::OFS_CNT:  rd_d = {uif[1].main_cnt, uif[1].sub_cnt,
                                       uif[0].main_cnt, uif[0].sub_cnt};
            tmu_pkg::OFS_POL:  rd_d = {30'h0000_0000, pol_q};
            default:           rd_d = 32'h0000_0000;
        endcase
    end

    // ========================================
    // Control registers
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            run_q  <= tmu_pkg::RST_RUN;
            mode_q <= tmu_pkg::RST_MODE;
            clk_q  <= tmu_pkg::RST_CLK;
            tff_q  <= tmu_pkg::RST_TFF;
            pol_q  <= tmu_pkg::RST_POL;
        end else if (wr_en) begin
            case (paddr_i)
                tmu_pkg::OFS_RUN:  run_q  <= pwdata_i[7:0];
                tmu_pkg::OFS_MODE: mode_q <= pwdata_i[7:0];
                tmu_pkg::OFS_CLK:  clk_q  <= pwdata_i[7:0];
                tmu_pkg::OFS_TFF:  tff_q  <= pwdata_i[7:0]
                                             & ~tmu_pkg::TFF_CMD_RD;
                tmu_pkg::OFS_POL:  pol_q  <= pwdata_i[1:0];
                default:           run_q  <= run_q;
            endcase
        end
    end

    // ========================================
    // Compare registers and 16-bit compare enable
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scmp_q[0] <= tmu_pkg::RST_CMP;
            scmp_q[1] <= tmu_pkg::RST_CMP;
            mcmp_q[0] <= tmu_pkg::RST_CMP;
            mcmp_q[1] <= tmu_pkg::RST_CMP;
            c16_q     <= tmu_pkg::RST_C16;
        end else if (wr_en) begin
            case (paddr_i)
                tmu_pkg::OFS_SCMP_A: begin
                    scmp_q[0] <= pwdata_i[7:0];
                    c16_q[0]  <= 1'b0;
                end
                tmu_pkg::OFS_MCMP_A: begin
                    mcmp_q[0] <= pwdata_i[7:0];
                    c16_q[0]  <= 1'b1;
                end
                tmu_pkg::OFS_SCMP_B: begin
                    scmp_q[1] <= pwdata_i[7:0];
                    c16_q[1]  <= 1'b0;
                end
                tmu_pkg::OFS_MCMP_B: begin
                    mcmp_q[1] <= pwdata_i[7:0];
                    c16_q[1]  <= 1'b1;
                end
                default: c16_q <= c16_q;
            endcase
        end
    end

    // ========================================
    // Prescaler
    assign wrap = run_q[tmu_pkg::PRE_RUN_BIT] & (pre_q == PRE_LAST);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre_q <= 5'h00;
            div_q <= 8'h00;
            tap_q <= 3'h0;
        end else if (!run_q[tmu_pkg::PRE_RUN_BIT]) begin
            pre_q <= 5'h00;
            div_q <= 8'h00;
            tap_q <= 3'h0;
        end else begin
            pre_q <= wrap ? 5'h00 : pre_q + 5'h01;
            if (wrap) begin
                div_q <= div_q + 8'h01;
            end
            tap_q[0] <= wrap;
            tap_q[1] <= wrap & ((div_q & T16_LAST) == T16_LAST);
            tap_q[2] <= wrap & ((div_q & PRESCALE_TAP_256_LAST) == PRESCALE_TAP_256_LAST);
        end
    end

    // ========================================
    // Tap spacing monitor
    // Counts cycles since the last fast tap; idle until the first tap
    // after a start, so a stop and restart is never taken as a bad gap.
    logic [4:0] tap_gap_q;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tap_gap_q <= GAP_IDLE;
        end else if (!run_q[tmu_pkg::PRE_RUN_BIT]) begin
            tap_gap_q <= GAP_IDLE;
        end else if (tap_q[0]) begin
            tap_gap_q <= 5'h00;
        end else if (tap_gap_q != GAP_IDLE) begin
            tap_gap_q <= tap_gap_q + 5'h01;
        end
    end

    // ========================================
    // Timer units
    for (genvar i = 0; i < 2; i++) begin : g_unit
        assign uif[i].sub_run  = run_q[2*i];
        assign uif[i].main_run = run_q[2*i+1];
        assign uif[i].mode     = tmu_pkg::tmu_mode_t'(mode_q[4*i+3 -: 2]);
        assign uif[i].pwm_n    = mode_q[4*i+1 -: 2];
        assign uif[i].sub_sel  = clk_q[4*i+1 -: 2];
        assign uif[i].main_sel = clk_q[4*i+3 -: 2];
        assign uif[i].inv_en   = tff_q[4*i+tmu_pkg::INV_EN_BIT];
        assign uif[i].ff_cmd   = tmu_pkg::tmu_ffcmd_t'(pwdata_i[4*i+3 -: 2]);
        assign uif[i].ff_cmd_valid = wr_en & (paddr_i == tmu_pkg::OFS_TFF)
                                     & (pwdata_i[4*i+3 -: 2]
                                        != tmu_pkg::FF_KEEP);
        assign uif[i].sub_cmp  = scmp_q[i];
        assign uif[i].main_cmp = mcmp_q[i];
        assign uif[i].cmp16_en = c16_q[i];
        assign uif[i].tap      = tap_q;

        tmu_unit u_unit (
            .clk_i   (clk_i),
            .rst_b_i (rst_b_i),
            .u       (uif[i])
        );
    end

    // ========================================
    // Output pins
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pulse_a_q <= 1'b0;
            pulse_b_q <= 1'b0;
        end else begin
            pulse_a_q <= uif[0].tff ^ pol_q[0];
            pulse_b_q <= uif[1].tff ^ pol_q[1];
        end
    end

    assign pulse_out_a_o = pulse_a_q;
    assign pulse_out_b_o = pulse_b_q;
    assign irq_trig_o    = {uif[1].trig, uif[0].trig};
    assign prdata_o      = prdata_q;
    assign pready_o      = pready_q;
    assign pslverr_o     = pslverr_q;

    // ========================================
    // Assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_ff_invert_cmd: assert property (
        uif[0].ff_cmd_valid && uif[0].ff_cmd == tmu_pkg::FF_INV
        |=> uif[0].tff != $past(uif[0].tff))
        else $error("Invert command did not invert output.");

    a_ff_force_level: assert property (
        uif[0].ff_cmd_valid && uif[0].ff_cmd != tmu_pkg::FF_KEEP
        && uif[0].ff_cmd != tmu_pkg::FF_INV
        |=> uif[0].tff == $past(uif[0].ff_cmd[0]))
        else $error("Force command gave wrong output level.");

    a_inv_gate_hold: assert property (
        !uif[0].inv_en && !uif[0].ff_cmd_valid |=> $stable(uif[0].tff))
        else $error("Output toggled with inversion disabled.");

    a_sub_write_block: assert property (
        wr_en && paddr_i == tmu_pkg::OFS_SCMP_A
        |=> !c16_q[0] && $stable(uif[0].main_cnt) or !c16_q[0])
        else $error("Sub compare write left 16-bit compare on.");

    a_tap_period: assert property (
        tap_gap_q != GAP_IDLE |-> tap_q[0] == (tap_gap_q == PRE_LAST))
        else $error("Fast tap period is not twenty cycles.");

    a_main_trig_clear: assert property (
        uif[0].mode == tmu_pkg::MODE_8BIT && uif[0].trig
        |-> uif[0].main_cnt == 8'h00)
        else $error("Interrupt without main counter clear.");

    a_wide_clear: assert property (
        uif[0].mode == tmu_pkg::MODE_16BIT && uif[0].trig
        |-> uif[0].main_cnt == 8'h00 && uif[0].sub_cnt == 8'h00)
        else $error("16-bit match did not clear both counters.");

    a_wide_carry: assert property (
        uif[0].mode == tmu_pkg::MODE_16BIT
        && $past(uif[0].mode) == tmu_pkg::MODE_16BIT
        && $changed(uif[0].main_cnt) && uif[0].main_cnt != 8'h00
        |-> $past(uif[0].sub_cnt) == 8'hFF)
        else $error("Main counter moved without sub overflow.");

    a_pwm_period: assert property (
        uif[0].mode == tmu_pkg::MODE_PWM && uif[0].trig
        |-> uif[0].main_cnt == 8'h00)
        else $error("PWM period did not clear main counter.");

    a_pwm_toggle: assert property (
        uif[0].mode == tmu_pkg::MODE_PWM && uif[0].trig
        && $past(uif[0].inv_en) && !$past(uif[0].ff_cmd_valid)
        |-> uif[0].tff != $past(uif[0].tff))
        else $error("PWM period did not toggle output.");

endmodule

// [verif/tmu_irq_sink.sv]
`timescale 1ns/10ps
// Counts trigger pulses and pin edges as the far side would see them.
module tmu_irq_sink (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    // Timer outputs
    input  wire logic [1:0] irq_trig_i,
    input  wire logic [1:0] pin_i,
    // Counts
    output int              irq_cnt_o [2],
    output int              tog_cnt_o [2]
);
    logic [1:0] pin_q;
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_q        <= 2'h0;
            irq_cnt_o    <= '{0, 0};
            tog_cnt_o    <= '{0, 0};
        end else begin
            pin_q <= pin_i;
            for (int i = 0; i < 2; i++) begin
                irq_cnt_o[i] <= irq_cnt_o[i] + int'(irq_trig_i[i]);
                tog_cnt_o[i] <= tog_cnt_o[i] + int'(pin_i[i] ^ pin_q[i]);
            end
        end
    end
endmodule

// [verif/tb_dual_8bit_timer_modes.sv]
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin \
    err_total++; $display("wrong value %s exp %0h got %0h", nm, ex, gt); \
    end end
module tb_dual_8bit_timer_modes;
    logic        clk_i = 0, rst_b_i = 0, psel_i = 0, penable_i = 0;
    logic        pwrite_i = 0, pslverr_o, pready_o, pa, pb;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic [1:0]  irq_trig_o;
    int          err_total = 0, n_compared = 0, c, t, ni, irqc [2], togc [2];
    integer      seed = 32'h66da691a;
    logic        er;
    tmu_top u_tmu_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .pulse_out_a_o(pa), .pulse_out_b_o(pb),
        .irq_trig_o(irq_trig_o));
    tmu_irq_sink u_tmu_irq_sink (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .irq_trig_i(irq_trig_o), .pin_i({pb, pa}), .irq_cnt_o(irqc),
        .tog_cnt_o(togc));
    always #12.5 clk_i = ~clk_i;
    // ========================================
    // Bus and measurement tasks
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        k = 0;
        // Ready and data are looked at mid-cycle, where they stand settled.
        do begin
            @(negedge clk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 50);
        if (k >= 50) err_total++;
        rd = prdata_o;
        er = pslverr_o;
        @(posedge clk_i);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task gap(input int u, output int n, output int tg, output int ni);
        int k, t0, i0;
        k = 0;
        do begin
            @(negedge clk_i);
            k++;
        end while (irq_trig_o[u] !== 1'b1 && k < 20000);
        t0 = togc[u];
        i0 = irqc[u];
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (irq_trig_o[u] !== 1'b1 && n < 20000);
        if (k >= 20000 || n >= 20000) err_total++;
        tg = togc[u] - t0;
        ni = irqc[u] - i0;
        @(posedge clk_i);
    endtask
    function automatic int ticks(input int n);
        return n * tmu_pkg::TAP1_CYC;
    endfunction
    task finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #(25 * 100000);
        err_total++;
        finish_test();
    end
    // Command code and expected pin level after it.
    logic [2:0] t2 [4] = '{3'b000, 3'b101, 3'b010, 3'b110};
    // ========================================
    // Main sequence
    initial begin
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        apb(0, tmu_pkg::OFS_MODE, 0);
        `CHK("mode", 32'h0, rd)
        apb(0, tmu_pkg::OFS_TFF, 0);
        `CHK("tff", 32'(tmu_pkg::TFF_CMD_RD), rd)
        // Compare values are written but never read back.
        apb(1, tmu_pkg::OFS_SCMP_B, $random(seed));
        apb(0, tmu_pkg::OFS_CNT, 0);
        `CHK("counters", 32'h0, rd)
        apb(0, 8'h40, 0);
        `CHK("slverr", 1'b1, er)
        // Clear, set, invert twice, then flip polarity.
        foreach (t2[i]) begin
            apb(1, tmu_pkg::OFS_TFF, {24'h0, 4'hC, t2[i][1:0], 2'h0});
            repeat (2) @(posedge clk_i);
            `CHK("pin a", t2[i][2], pa)
        end
        apb(1, tmu_pkg::OFS_POL, 32'h1);
        repeat (2) @(posedge clk_i);
        `CHK("polarity", 1'b0, pa)
        apb(1, tmu_pkg::OFS_POL, 32'h0);
        apb(1, tmu_pkg::OFS_TFF, 32'hFF);
        apb(1, tmu_pkg::OFS_CLK, 32'h51);
        apb(1, tmu_pkg::OFS_SCMP_A, 32'h2);
        apb(1, tmu_pkg::OFS_MCMP_A, 32'h3);
        apb(1, tmu_pkg::OFS_SCMP_B, 32'h1);
        apb(1, tmu_pkg::OFS_MCMP_B, 32'h0);
        apb(1, tmu_pkg::OFS_RUN, 32'h2F);
        gap(0, c, t, ni);
        `CHK("cascade gap", ticks(6), c)
        `CHK("toggles a", 1, t)
        `CHK("irqs a", 1, ni)
        gap(1, c, t, ni);
        `CHK("zero cmp gap", ticks(256), c)
        `CHK("toggles b", 1, t)
        apb(1, tmu_pkg::OFS_RUN, 32'h0);
        apb(1, tmu_pkg::OFS_MODE, 32'h4);
        apb(1, tmu_pkg::OFS_SCMP_A, 32'h2);
        apb(1, tmu_pkg::OFS_MCMP_A, 32'h1);
        apb(1, tmu_pkg::OFS_RUN, 32'h23);
        gap(0, c, t, ni);
        `CHK("16 bit gap", ticks(258), c)
        `CHK("toggles 16", 1, t)
        apb(1, tmu_pkg::OFS_RUN, 32'h0);
        apb(1, tmu_pkg::OFS_MODE, 32'h8);
        apb(1, tmu_pkg::OFS_CLK, 32'h55);
        apb(1, tmu_pkg::OFS_SCMP_A, 32'h1);
        apb(1, tmu_pkg::OFS_MCMP_A, 32'h4);
        apb(1, tmu_pkg::OFS_RUN, 32'h23);
        gap(0, c, t, ni);
        `CHK("pulse gap", ticks(4), c)
        `CHK("pulse toggles", 2, t)
        apb(1, tmu_pkg::OFS_RUN, 32'h0);
        apb(1, tmu_pkg::OFS_MODE, 32'hD);
        c = ($unsigned($random(seed)) % 62) + 1;
        apb(1, tmu_pkg::OFS_MCMP_A, c);
        apb(1, tmu_pkg::OFS_RUN, 32'h22);
        gap(0, c, t, ni);
        `CHK("pwm gap", ticks(63), c)
        `CHK("pwm toggles", 2, t)
        finish_test();
    end
endmodule
